// >>> shared/fps_map.svh
// offsets, command codes, status fields and timing counts for the flash host
// assumes a 32-bit apb register port and a 20 mhz pclk
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH
// apb register offsets (byte addresses)
`define FPS_OFF_CTRL      12'h000
`define FPS_OFF_ADDR      12'h004
`define FPS_OFF_WDATA     12'h008
`define FPS_OFF_STATUS    12'h00c
`define FPS_OFF_RESULT    12'h010
// control register fields
`define FPS_CTRL_GO       0
`define FPS_CTRL_OP_LO    1
`define FPS_CTRL_OP_HI    3
`define FPS_CTRL_ALT      4
// flash command codes
`define FPS_CMD_READ_ARRAY 8'hff
`define FPS_CMD_READ_STAT  8'h70
`define FPS_CMD_CLEAR_STAT 8'h50
`define FPS_CMD_PROG       8'h40
`define FPS_CMD_PROG_ALT   8'h10
`define FPS_CMD_RESUME     8'hd0
// status byte bit positions
`define FPS_SB_READY      7
`define FPS_SB_SUSP       6
`define FPS_SB_ERASE_FAIL 5
`define FPS_SB_PROG_FAIL  4
`define FPS_SB_SUPPLY_LOW 3
`define FPS_SB_VALID_MASK 8'hf8
// bus cycle timing: strobe width and gap in ns, cycles derived
`define FPS_T_STROBE_NS   100
`define FPS_T_GAP_NS      50
`define FPS_CLK_NS        50
`define FPS_STROBE_CYC    ((`FPS_T_STROBE_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_GAP_CYC       ((`FPS_T_GAP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`endif

// >>> shared/fps_pkg.sv
// types for the flash program-sequence host
// assumes fps_map.svh supplies the numbers
package fps_pkg;
    // operations software may request
    typedef enum logic [2:0] {
        FPS_OP_READ_STATUS,
        FPS_OP_CLEAR_STATUS,
        FPS_OP_READ_ARRAY,
        FPS_OP_PROGRAM,
        FPS_OP_RESUME,
        FPS_OP_READ
    } fps_op_t;
endpackage

// >>> design/fps_host.sv
// apb-driven host that issues commands to a boot-block flash and polls status
// assumes the flash pins are asynchronous to pclk; read data is synchronised
//
// Functional notes
// - write ffh to return to array
// - host toggles enable for every poll
// - host clears status before new command; this host sends 50h only when software requests the clear-status op
// - read array needed before array data
// - program is setup write then data
// - only read status while programming
// - setup code 40h or 10h accepted
`timescale 1ns/10ps
`include "fps_map.svh"
module fps_host #(
    parameter int AW = 19,                  // flash address width
    parameter int DW = 16                   // flash data width
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output logic [AW-1:0]      flash_addr,
    output logic               chip_enable_n,
    output logic               output_enable_n,
    output logic               write_enable_n,
    output logic [DW-1:0]      flash_dq_out,
    output logic               flash_dq_oe_n,
    input  wire logic [DW-1:0] flash_dq_in
);
    import fps_pkg::*;

    typedef enum logic [2:0] {
        FPS_IDLE, FPS_SETUP, FPS_STROBE, FPS_SAMPLE, FPS_GAP, FPS_DONE
    } fps_state_t;

    localparam logic [3:0] STROBE_N = 4'(`FPS_STROBE_CYC); // strobe width
    localparam logic [3:0] GAP_N    = 4'(`FPS_GAP_CYC);    // gap between strobes

    fps_state_t        state_q;           // bus cycle sequencer
    logic [3:0]        cnt_q;             // cycle timer
    logic              is_read_q;         // current cycle is a read
    logic              second_q;          // second write of program pending
    fps_op_t           op_q;              // latched operation
    logic              alt_q;             // use alternate setup code
    logic [AW-1:0]     addr_q;            // software target address
    logic [DW-1:0]     wdata_q;           // software program data
    logic [DW-1:0]     result_q;          // last read value
    logic              busy_q;            // operation in flight
    logic              in_status_q;       // flash known to be in status mode
    logic [DW-1:0]     sync1_q;           // first synchroniser stage
    logic [DW-1:0]     sync2_q;           // second synchroniser stage

    // apb decode helpers
    logic wr_en;
    logic rd_en;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;                // zero wait state slave
    assign pslverr = 1'b0;

    // command byte chosen for the first strobe of each operation
    function automatic logic [7:0] cmd_of(input fps_op_t op, input logic alt);
        unique case (op)
            FPS_OP_READ_STATUS:  cmd_of = `FPS_CMD_READ_STAT;
            FPS_OP_CLEAR_STATUS: cmd_of = `FPS_CMD_CLEAR_STAT;
            FPS_OP_READ_ARRAY:   cmd_of = `FPS_CMD_READ_ARRAY;
            FPS_OP_PROGRAM:      cmd_of = alt ? `FPS_CMD_PROG_ALT : `FPS_CMD_PROG;
            FPS_OP_RESUME:       cmd_of = `FPS_CMD_RESUME;
            FPS_OP_READ:         cmd_of = `FPS_CMD_READ_STAT;
            default:             cmd_of = `FPS_CMD_READ_STAT;   // unused op codes poll only
        endcase
    endfunction

    // software-written registers; go ignored while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q    <= FPS_OP_READ_STATUS;
            alt_q   <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
        end else if (wr_en && !busy_q) begin
            unique case (paddr)
                `FPS_OFF_CTRL: begin
                    op_q  <= fps_op_t'(pwdata[`FPS_CTRL_OP_HI:`FPS_CTRL_OP_LO]);
                    alt_q <= pwdata[`FPS_CTRL_ALT];
                end
                `FPS_OFF_ADDR:  addr_q  <= pwdata[AW-1:0];
                `FPS_OFF_WDATA: wdata_q <= pwdata[DW-1:0];
                default: ;
            endcase
        end
    end

    // read mux; status word masks reserved bits
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            unique case (paddr)
                `FPS_OFF_CTRL:   prdata = {28'h0, alt_q, op_q};
                `FPS_OFF_ADDR:   prdata = 32'(addr_q);
                `FPS_OFF_WDATA:  prdata = 32'(wdata_q);
                `FPS_OFF_STATUS: prdata = {16'h0, 7'h0, in_status_q,
                                           result_q[7:0] & `FPS_SB_VALID_MASK};
                `FPS_OFF_RESULT: prdata = {15'h0, busy_q, result_q};
                default:         prdata = 32'h0000_0000;
            endcase
        end
    end

    // two-stage synchroniser on flash read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= flash_dq_in;
            sync2_q <= sync1_q;
        end
    end

    // bus cycle sequencer: one enable-low pulse per command or poll
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= FPS_IDLE;
            cnt_q     <= 4'h0;
            is_read_q <= 1'b0;
            second_q  <= 1'b0;
            busy_q    <= 1'b0;
            result_q  <= '0;
            in_status_q <= 1'b0;
        end else begin
            unique case (state_q)
                FPS_IDLE: begin
                    if (wr_en && paddr == `FPS_OFF_CTRL && pwdata[`FPS_CTRL_GO] && !busy_q) begin
                        busy_q    <= 1'b1;
                        // plain read issues no command; it reads in whatever mode the flash is already in
                        is_read_q <= (fps_op_t'(pwdata[`FPS_CTRL_OP_HI:`FPS_CTRL_OP_LO])
                                      == FPS_OP_READ);
                        second_q  <= 1'b0;
                        state_q   <= FPS_SETUP;
                    end
                end
                FPS_SETUP: begin
                    cnt_q   <= STROBE_N;
                    state_q <= FPS_STROBE;
                end
                FPS_STROBE: begin
                    if (cnt_q > 4'h1) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else begin
                        state_q <= FPS_SAMPLE;     // enables rise at this edge
                    end
                end
                FPS_SAMPLE: begin
                    // two-flop latency: data seen at the strobe's first edge is now in
                    // sync2_q; needs a strobe of two cycles or more; each poll is fresh
                    if (is_read_q) result_q <= sync2_q;
                    cnt_q   <= GAP_N;
                    state_q <= FPS_GAP;
                end
                FPS_GAP: begin
                    if (cnt_q > 4'h1) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (op_q == FPS_OP_PROGRAM && !second_q && !is_read_q) begin
                        second_q <= 1'b1;          // data write follows setup
                        state_q  <= FPS_SETUP;
                    end else if (!is_read_q && op_q != FPS_OP_CLEAR_STATUS
                                 && op_q != FPS_OP_READ_ARRAY && op_q != FPS_OP_RESUME) begin
                        // program ends by polling until ready; read-status ends after one status read
                        is_read_q <= 1'b1;         // only status reads while busy
                        state_q   <= FPS_SETUP;
                    end else if (is_read_q && op_q == FPS_OP_PROGRAM
                                 && !result_q[`FPS_SB_READY]) begin
                        state_q <= FPS_SETUP;      // poll again with new strobe
                    end else begin
                        state_q <= FPS_DONE;
                    end
                end
                FPS_DONE: begin
                    // flash is in status mode after program or 70h, array after ffh
                    in_status_q <= (op_q != FPS_OP_READ_ARRAY) &&
                                   (op_q != FPS_OP_READ || in_status_q);
                    busy_q  <= 1'b0;
                    state_q <= FPS_IDLE;
                end
            endcase
        end
    end

    // flash pin drive from sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_enable_n   <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n  <= 1'b1;
            flash_dq_oe_n   <= 1'b1;
            flash_dq_out    <= '0;
            flash_addr      <= '0;
        end else if (state_q == FPS_SETUP) begin
            chip_enable_n   <= 1'b0;
            output_enable_n <= !is_read_q;
            write_enable_n  <= is_read_q;
            flash_dq_oe_n   <= is_read_q;
            flash_addr      <= addr_q;
            flash_dq_out    <= second_q ? wdata_q : DW'(cmd_of(op_q, alt_q));
        end else if (state_q == FPS_STROBE && cnt_q == 4'h1) begin
            chip_enable_n   <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n  <= 1'b1;
        end else if (state_q == FPS_GAP) begin
            flash_dq_oe_n   <= 1'b1;
        end
    end

    // enables must rise between successive polls
    property p_poll_toggle;
        @(posedge pclk) disable iff (!presetn)
        (state_q == FPS_GAP) |-> output_enable_n && chip_enable_n;
    endproperty
    a_poll_toggle: assert property (p_poll_toggle) else $error("enable low between polls");

    // data write follows setup write within a bounded window
    property p_prog_pair;
        @(posedge pclk) disable iff (!presetn)
        (state_q == FPS_SETUP && op_q == FPS_OP_PROGRAM && !second_q && !is_read_q)
            |-> ##[1:12] (state_q == FPS_SETUP && second_q);
    endproperty
    a_prog_pair: assert property (p_prog_pair) else $error("program data write missing");

    // after the data write only reads are issued until done
    property p_only_status;
        @(posedge pclk) disable iff (!presetn)
        (busy_q && op_q == FPS_OP_PROGRAM && second_q && is_read_q) |-> write_enable_n;
    endproperty
    a_only_status: assert property (p_only_status) else $error("write during program");

    // setup code is one of the two accepted values
    property p_setup_code;
        @(posedge pclk) disable iff (!presetn)
        (op_q == FPS_OP_PROGRAM && !second_q && !write_enable_n)
            |-> (flash_dq_out[7:0] == `FPS_CMD_PROG || flash_dq_out[7:0] == `FPS_CMD_PROG_ALT);
    endproperty
    a_setup_code: assert property (p_setup_code) else $error("bad setup code");

    // reserved status bits never reach software through the status register; the result register returns them raw
    property p_mask;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == `FPS_OFF_STATUS) |-> prdata[2:0] == 3'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("reserved bits visible");

    // a read strobe never meets host-driven data or a write strobe
    property p_read_release;
        @(posedge pclk) disable iff (!presetn)
        (!output_enable_n) |-> flash_dq_oe_n && write_enable_n;
    endproperty
    a_read_release: assert property (p_read_release) else $error("dq driven in read");

endmodule // fps_host

// >>> tb/fps_flash_model.sv
// behavioural flash device: command decode, status byte and program sequence
// assumes the pins of fps_host; the device has no clock, all timing is in ns
`timescale 1ns/10ps
`include "fps_map.svh"
module fps_flash_model #(
    parameter int AW      = 19,  // address width
    parameter int PROG_NS = 900  // self-timed program length
) (
    input  wire logic [AW-1:0] flash_addr,
    input  wire logic          chip_enable_n,
    input  wire logic          output_enable_n,
    input  wire logic          write_enable_n,
    input  wire logic [15:0]   flash_dq_out,
    input  wire logic          flash_dq_oe_n,
    input  wire logic          supply_ok,  // program supply in limits
    input  wire logic          fail_next,  // next program fails verify
    output logic      [15:0]   flash_dq_in
);
    logic [15:0] mem_q [16];  // small array on low address bits
    logic [7:0]  stat_q;      // status byte; erase fail bit stays 0, no erase here
    logic        stat_mode_q; // reads return status
    logic        armed_q;     // setup write seen
    logic [15:0] rd_q;        // last value put on the bus
    logic [15:0] wr_d;        // data of the current write
    logic [3:0]  wr_a;        // address of the current write
    initial begin
        foreach (mem_q[i]) mem_q[i] = 16'hffff;
        stat_q = 8'h80;
        stat_mode_q = 0;
        armed_q = 0;
        rd_q = 16'h0;
    end
    // self-timed program then verify
    task automatic prog_run(input logic [3:0] a, input logic [15:0] d);
        #(PROG_NS);
        mem_q[a] = mem_q[a] & d;
        if (fail_next) stat_q[4] = 1;
        stat_q[7] = 1;
    endtask
    // sample data 10 ns after the write strobe falls
    always @(negedge write_enable_n) begin
        #10;
        wr_d = flash_dq_oe_n ? 16'hxxxx : flash_dq_out;  // undriven data decodes as nothing
        wr_a = flash_addr[3:0];
    end
    // command decode at the end of the write strobe
    always @(posedge write_enable_n) begin
        if (!stat_q[7]) begin
            if (wr_d[7:0] == `FPS_CMD_READ_STAT) stat_mode_q = 1;
        end else if (armed_q) begin
            armed_q = 0;
            if (!supply_ok) stat_q[3] = 1;
            else begin
                stat_q[7] = 0;
                fork
                    prog_run(wr_a, wr_d);
                join_none
            end
        end else begin
            case (wr_d[7:0])
                `FPS_CMD_READ_STAT:  stat_mode_q = 1;
                `FPS_CMD_CLEAR_STAT: stat_q[5:3] = 3'b000;
                `FPS_CMD_READ_ARRAY: stat_mode_q = 0;
                `FPS_CMD_RESUME:     stat_q[6] = 0;
                `FPS_CMD_PROG, `FPS_CMD_PROG_ALT: begin
                    armed_q = 1;
                    stat_mode_q = 1;
                end
                default: ;
            endcase
        end
    end
    // capture when the later enable falls, hold for the read
    always @(negedge output_enable_n or negedge chip_enable_n) begin
        #1;
        if (!output_enable_n && !chip_enable_n)
            // word-wide part only; byte-wide lane release is not modelled
            rd_q = stat_mode_q ? {8'h00, stat_q} : mem_q[flash_addr[3:0]];
    end
    // released bus shows the inverse of the last value
    assign flash_dq_in = (!chip_enable_n && !output_enable_n) ? rd_q : ~rd_q;
endmodule // fps_flash_model

// >>> tb/tb_top.sv
// self-checking bench for fps_host with a behavioural flash
// assumes the zero-wait apb slave and register map of fps_host
`timescale 1ns/10ps
`include "fps_map.svh"
module tb_top;
    import fps_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, ce_n, oe_n, we_n, dq_oe_n;
    logic [18:0] faddr;
    logic [15:0] dq_out, dq_in;
    logic        supply_ok, fail_next;
    int          n_fail = 0;
    int          checked = 0;
    int          cycles = 0;
    logic        last_err;    // pslverr of the last transfer
    fps_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flash_addr(faddr), .chip_enable_n(ce_n),
        .output_enable_n(oe_n), .write_enable_n(we_n), .flash_dq_out(dq_out),
        .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in));
    fps_flash_model i_flash (.flash_addr(faddr), .chip_enable_n(ce_n),
        .output_enable_n(oe_n), .write_enable_n(we_n), .flash_dq_out(dq_out),
        .flash_dq_oe_n(dq_oe_n), .supply_ok(supply_ok), .fail_next(fail_next),
        .flash_dq_in(dq_in));
    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // start an operation and poll busy
    task automatic run_op(input fps_op_t op, input logic alt);
        logic [31:0] q;
        apb(1, `FPS_OFF_CTRL, {27'h0, alt, op, 1'b1}, q);
        do apb(0, `FPS_OFF_RESULT, 0, q); while (q[16] !== 1'b0);
    endtask
    task automatic prog(input logic [18:0] a, input logic [15:0] d, input logic alt);
        logic [31:0] q;
        apb(1, `FPS_OFF_ADDR, {13'h0, a}, q);
        apb(1, `FPS_OFF_WDATA, {16'h0, d}, q);
        run_op(FPS_OP_PROGRAM, alt);
    endtask
    task automatic rd_status(input logic [7:0] exp);
        logic [31:0] q;
        run_op(FPS_OP_READ_STATUS, 0);
        apb(0, `FPS_OFF_STATUS, 0, q);
        chk("status", {23'h0, 1'b1, exp}, q);
        apb(0, `FPS_OFF_RESULT, 0, q);
        chk("status word", {24'h0, exp}, q);
    endtask
    task automatic rd_array(input logic [18:0] a, input logic [15:0] exp);
        logic [31:0] q;
        apb(1, `FPS_OFF_ADDR, {13'h0, a}, q);
        run_op(FPS_OP_READ_ARRAY, 0);
        run_op(FPS_OP_READ, 0);
        apb(0, `FPS_OFF_RESULT, 0, q);
        chk("array", {16'h0, exp}, q);
    endtask
    // idle status and an unmapped read
    task automatic s_reset();
        logic [31:0] q;
        rd_status(8'h80);
        apb(0, 12'h020, 0, q);
        chk("unmapped", 32'h0, q);
        chk("slverr", 32'h0, {31'h0, last_err});
    endtask
    // program, then ones-over-zeros with the alternate setup
    task automatic s_program();
        prog(19'h3, 16'h12f0, 0);
        rd_status(8'h80);
        rd_array(19'h3, 16'h12f0);
        prog(19'h3, 16'hff0f, 1);
        rd_status(8'h80);
        rd_array(19'h3, 16'h1200);
    endtask
    // busy seen once after go, then polled until it clears
    task automatic s_busy();
        logic [31:0] q;
        apb(1, `FPS_OFF_CTRL, {27'h0, 1'b0, FPS_OP_PROGRAM, 1'b1}, q);
        apb(0, `FPS_OFF_RESULT, 0, q);
        chk("busy", 32'h1, {31'h0, q[16]});
        do apb(0, `FPS_OFF_RESULT, 0, q); while (q[16] !== 1'b0);
    endtask
    // supply low, failed program, accumulate, clear, resume
    task automatic s_errors();
        supply_ok <= 0;
        prog(19'h5, 16'h0000, 0);
        rd_status(8'h88);
        supply_ok <= 1;
        fail_next <= 1;
        prog(19'h6, 16'h00ff, 0);
        fail_next <= 0;
        rd_status(8'h98);
        run_op(FPS_OP_CLEAR_STATUS, 0);
        rd_status(8'h80);
        run_op(FPS_OP_RESUME, 0);
        rd_status(8'h80);
    endtask
    initial begin
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        supply_ok = 1;
        fail_next = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        s_reset();
        s_program();
        s_busy();
        s_errors();
        print_verdict();
    end
endmodule // tb_top
